/* File: logic/see_slave.sv */
// Two-wire serial EEPROM slave: bus conditions, byte framing, 4K x 8 array.
// Assumes a bus master drives the serial clock; the data pin is open drain.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - SDA falling with SCL high is start.
// - SDA rising with SCL high is stop.
// - Both lines high means bus idle.
// - SDA change during SCL high is condition.
// - Change SDA only while SCL low.
// - Addressed receiver acknowledges every received byte.
// - No acknowledge during internal write cycle.
// - Acknowledge holds SDA low through clock high.
// - On master no-acknowledge, release SDA high.
// - Hold SDA 300 ns after SCL falls.
// - Ignore input spikes up to 50 ns.
// - Write cycle self-timed, about 2 ms.
// - Byte write and 32-byte page write.
// - Eight devices may share one bus.
// - Control byte last bit: one read.
// - Answer only when select bits match pins.
// - Stop after write data launches write.
// - Page write increments low five bits, wraps.
module see_slave
    import see_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_n_o,
    input  wire logic [2:0] chip_select_pins_i,
    output var  logic       busy_o
);

    logic                scl_f;
    logic                sda_f;
    logic                scl_d_ff;
    logic                sda_d_ff;
    logic [2:0]          cs_meta_ff;
    logic [2:0]          cs_sync_ff;

    see_state_e          state_ff;
    see_state_e          nxt_state;
    see_phase_e          phase_ff;
    see_phase_e          nxt_phase;
    logic [3:0]          bit_ff;
    logic [3:0]          nxt_bit;
    logic [7:0]          shift_ff;
    logic [7:0]          nxt_shift;
    logic                rd_mode_ff;
    logic                nxt_rd_mode;
    logic                mack_ff;
    logic                nxt_mack;
    logic [ADDR_W-1:0]   addr_ff;
    logic [ADDR_W-1:0]   nxt_addr;
    logic                want_low_ff;
    logic                nxt_want_low;
    logic                drive_low_ff;
    logic                nxt_drive_low;
    logic [HOLD_W-1:0]   hold_ff;
    logic [HOLD_W-1:0]   nxt_hold;
    logic                busy_ff;
    logic                nxt_busy;
    logic [WTIMER_W-1:0] wtimer_ff;
    logic [WTIMER_W-1:0] nxt_wtimer;
    logic                commit;
    logic                store;
    logic                pend_ff;
    logic                nxt_pend;
    logic [ADDR_W-PAGE_W-1:0] page_ff;
    logic [ADDR_W-PAGE_W-1:0] nxt_page;

    logic [7:0]          mem_ff [0:MEM_DEPTH-1];
    logic [7:0]          pbuf_ff [0:PAGE_DEPTH-1];
    logic [PAGE_DEPTH-1:0] pvld_ff;

    logic                scl_rise;
    logic                scl_fall;
    logic                start_det;
    logic                stop_det;
    logic                sel_match;

    see_pin_filter u_scl_filter (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .pin_i     (scl_i),
        .clean_o   (scl_f)
    );

    see_pin_filter u_sda_filter (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .pin_i     (sda_i),
        .clean_o   (sda_f)
    );

    // Edges and bus conditions from the filtered lines.
    assign scl_rise  = scl_f & ~scl_d_ff;
    assign scl_fall  = ~scl_f & scl_d_ff;
    assign start_det = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
    assign stop_det  = scl_f & scl_d_ff & ~sda_d_ff & sda_f;
    assign sel_match = (shift_ff[7:4] == CTRL_CODE) && (shift_ff[3:1] == cs_sync_ff);

    always_comb begin
        nxt_state     = state_ff;
        nxt_phase     = phase_ff;
        nxt_bit       = bit_ff;
        nxt_shift     = shift_ff;
        nxt_rd_mode   = rd_mode_ff;
        nxt_mack      = mack_ff;
        nxt_addr      = addr_ff;
        nxt_want_low  = want_low_ff;
        nxt_pend      = pend_ff;
        nxt_page      = page_ff;
        store         = 1'b0;
        if (start_det) begin
            nxt_state    = SEE_RX;
            nxt_phase    = SEE_PH_CTRL;
            nxt_bit      = BIT_ZERO;
            nxt_want_low = 1'b0;
            nxt_pend     = 1'b0;
        end else if (stop_det) begin
            nxt_state    = SEE_IDLE;
            nxt_want_low = 1'b0;
            nxt_pend     = 1'b0;
        end else begin
            case (state_ff)
                SEE_IDLE: begin
                    nxt_want_low = 1'b0;
                end
                SEE_RX: begin
                    if (scl_rise && bit_ff != BIT_LAST) begin
                        nxt_shift = {shift_ff[6:0], sda_f};
                        nxt_bit   = bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == BIT_LAST) begin
                        nxt_state    = SEE_RX_ACK;
                        nxt_want_low = 1'b1;
                        case (phase_ff)
                            SEE_PH_CTRL: begin
                                nxt_rd_mode = shift_ff[0];
                                if (!sel_match || busy_ff) begin
                                    nxt_state    = SEE_WAIT;
                                    nxt_want_low = 1'b0;
                                end
                            end
                            SEE_PH_ADRH: begin
                                nxt_addr = {shift_ff[3:0], addr_ff[7:0]};
                            end
                            SEE_PH_ADRL: begin
                                nxt_addr = {addr_ff[ADDR_W-1:8], shift_ff};
                            end
                            SEE_PH_DATA: begin
                                store    = 1'b1;
                                nxt_pend = 1'b1;
                                nxt_page = addr_ff[ADDR_W-1:PAGE_W];
                                nxt_addr = {addr_ff[ADDR_W-1:PAGE_W], addr_ff[PAGE_W-1:0] + PAGE_W'(1)};
                            end
                            default: begin
                                nxt_state = SEE_WAIT;
                            end
                        endcase
                    end
                end
                SEE_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_bit = BIT_ZERO;
                        if (phase_ff == SEE_PH_CTRL && rd_mode_ff) begin
                            nxt_state    = SEE_TX;
                            nxt_shift    = {mem_ff[addr_ff][6:0], 1'b0};
                            nxt_want_low = ~mem_ff[addr_ff][7];
                            nxt_addr     = addr_ff + ADDR_W'(1);
                        end else begin
                            nxt_state    = SEE_RX;
                            nxt_want_low = 1'b0;
                            case (phase_ff)
                                SEE_PH_CTRL: nxt_phase = SEE_PH_ADRH;
                                SEE_PH_ADRH: nxt_phase = SEE_PH_ADRL;
                                default:     nxt_phase = SEE_PH_DATA;
                            endcase
                        end
                    end
                end
                SEE_TX: begin
                    if (scl_rise) begin
                        nxt_bit = bit_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_ff == BIT_LAST) begin
                            nxt_state    = SEE_TX_ACK;
                            nxt_want_low = 1'b0;
                        end else begin
                            nxt_want_low = ~shift_ff[7];
                            nxt_shift    = {shift_ff[6:0], 1'b0};
                        end
                    end
                end
                SEE_TX_ACK: begin
                    if (scl_rise) begin
                        nxt_mack = ~sda_f;
                    end else if (scl_fall) begin
                        nxt_bit = BIT_ZERO;
                        if (mack_ff) begin
                            nxt_state    = SEE_TX;
                            nxt_shift    = {mem_ff[addr_ff][6:0], 1'b0};
                            nxt_want_low = ~mem_ff[addr_ff][7];
                            nxt_addr     = addr_ff + ADDR_W'(1);
                        end else begin
                            nxt_state    = SEE_WAIT;
                            nxt_want_low = 1'b0;
                        end
                    end
                end
                SEE_WAIT: begin
                    nxt_want_low = 1'b0;
                end
                default: begin
                    nxt_state    = SEE_IDLE;
                    nxt_want_low = 1'b0;
                end
            endcase
        end
    end

    // The pin follows the wanted level only once the hold-off after a clock fall has run out.
    always_comb begin
        nxt_hold      = hold_ff;
        nxt_drive_low = drive_low_ff;
        if (scl_fall) begin
            nxt_hold = HOLD_LOAD;
        end else if (hold_ff != '0) begin
            nxt_hold = hold_ff - HOLD_W'(1);
        end else begin
            nxt_drive_low = want_low_ff & ~busy_ff;
        end
    end

    // Self-timed write cycle started by a stop after write data.
    always_comb begin
        nxt_busy   = busy_ff;
        nxt_wtimer = wtimer_ff;
        commit     = 1'b0;
        if (busy_ff) begin
            if (wtimer_ff == '0) begin
                nxt_busy = 1'b0;
                commit   = 1'b1;
            end else begin
                nxt_wtimer = wtimer_ff - WTIMER_W'(1);
            end
        end else if (stop_det && pend_ff) begin
            nxt_busy   = 1'b1;
            nxt_wtimer = WTIMER_W'(WRITE_CYCLES - 1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            scl_d_ff     <= 1'b1;
            sda_d_ff     <= 1'b1;
            cs_meta_ff   <= 3'h0;
            cs_sync_ff   <= 3'h0;
            state_ff     <= SEE_IDLE;
            phase_ff     <= SEE_PH_CTRL;
            bit_ff       <= BIT_ZERO;
            shift_ff     <= BYTE_ZERO;
            rd_mode_ff   <= 1'b0;
            mack_ff      <= 1'b0;
            addr_ff      <= ADDR_RST;
            want_low_ff  <= 1'b0;
            drive_low_ff <= 1'b0;
            hold_ff      <= '0;
            busy_ff      <= 1'b0;
            wtimer_ff    <= '0;
            pend_ff      <= 1'b0;
            page_ff      <= '0;
        end else begin
            scl_d_ff     <= scl_f;
            sda_d_ff     <= sda_f;
            cs_meta_ff   <= chip_select_pins_i;
            cs_sync_ff   <= cs_meta_ff;
            state_ff     <= nxt_state;
            phase_ff     <= nxt_phase;
            bit_ff       <= nxt_bit;
            shift_ff     <= nxt_shift;
            rd_mode_ff   <= nxt_rd_mode;
            mack_ff      <= nxt_mack;
            addr_ff      <= nxt_addr;
            want_low_ff  <= nxt_want_low;
            drive_low_ff <= nxt_drive_low;
            hold_ff      <= nxt_hold;
            busy_ff      <= nxt_busy;
            wtimer_ff    <= nxt_wtimer;
            pend_ff      <= nxt_pend;
            page_ff      <= nxt_page;
        end
    end

    // Page buffer collects write data; the array takes it when the write cycle ends.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pvld_ff <= '0;
        end else if (commit || (!busy_ff && (start_det || (stop_det && !pend_ff)))) begin
            pvld_ff <= '0;
        end else if (store) begin
            pvld_ff[addr_ff[PAGE_W-1:0]] <= 1'b1;
        end
        if (store) begin
            pbuf_ff[addr_ff[PAGE_W-1:0]] <= shift_ff;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < PAGE_DEPTH; i++) begin
            if (commit && pvld_ff[i]) begin
                mem_ff[{page_ff, PAGE_W'(i)}] <= pbuf_ff[i];
            end
        end
    end

    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~drive_low_ff;
    assign busy_o     = busy_ff;

endmodule // see_slave
`default_nettype wire

/* File: shared/see_pkg.sv */
// Constants for the two-wire serial EEPROM slave.
// Assumes a 50 MHz system clock that samples the bus pins.
package see_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SPIKE_NS      = 50;
    localparam int unsigned HOLD_OFF_NS   = 300;
    localparam int unsigned WRITE_TIME_US = 2000;

    localparam int unsigned SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_OFF_CYC  = (HOLD_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYC     = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

    localparam int unsigned FILT_W        = 3;
    localparam int unsigned HOLD_W        = 5;
    localparam int unsigned WTIMER_W      = 20;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned PAGE_W        = 5;
    localparam int unsigned MEM_DEPTH     = 4096;
    localparam int unsigned PAGE_DEPTH    = 32;

    localparam logic [FILT_W-1:0]   FILT_LIMIT = FILT_W'(SPIKE_CYC + 1);
    localparam logic [HOLD_W-1:0]   HOLD_LOAD  = HOLD_W'(HOLD_OFF_CYC);
    localparam logic [3:0]          BIT_LAST   = 4'h8;
    localparam logic [3:0]          BIT_ZERO   = 4'h0;
    localparam logic [ADDR_W-1:0]   ADDR_RST   = 12'h000;
    localparam logic [7:0]          BYTE_ZERO  = 8'h00;

    // Control code value is arbitrary; set it to the code the system expects.
    localparam logic [3:0]          CTRL_CODE  = 4'h5;

    typedef enum logic [5:0] {
        SEE_IDLE   = 6'b00_0001,
        SEE_RX     = 6'b00_0010,
        SEE_RX_ACK = 6'b00_0100,
        SEE_TX     = 6'b00_1000,
        SEE_TX_ACK = 6'b01_0000,
        SEE_WAIT   = 6'b10_0000
    } see_state_e;

    typedef enum logic [3:0] {
        SEE_PH_CTRL  = 4'b0001,
        SEE_PH_ADRH  = 4'b0010,
        SEE_PH_ADRL  = 4'b0100,
        SEE_PH_DATA  = 4'b1000
    } see_phase_e;

endpackage

/* File: logic/see_pin_filter.sv */
// Synchroniser and spike filter for one bus input pin.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
module see_pin_filter
    import see_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    input  wire logic pin_i,
    output var  logic clean_o
);

    logic              meta_ff;
    logic              sync_ff;
    logic              clean_ff;
    logic [FILT_W-1:0] cnt_ff;
    logic              nxt_clean;
    logic [FILT_W-1:0] nxt_cnt;

    // A new level is taken only after it has stood longer than a spike can last.
    always_comb begin
        nxt_clean = clean_ff;
        nxt_cnt   = '0;
        if (sync_ff != clean_ff) begin
            nxt_cnt = cnt_ff + FILT_W'(1);
            if (nxt_cnt == FILT_LIMIT) begin
                nxt_clean = sync_ff;
                nxt_cnt   = '0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            meta_ff  <= 1'b1;
            sync_ff  <= 1'b1;
            clean_ff <= 1'b1;
            cnt_ff   <= '0;
        end else begin
            meta_ff  <= pin_i;
            sync_ff  <= meta_ff;
            clean_ff <= nxt_clean;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign clean_o = clean_ff;

endmodule // see_pin_filter
`default_nettype wire

/* File: test/see_slave_assertions.sv */
// Pin checker for the serial EEPROM slave.
// Assumes sda_i carries the resolved wire level.
`timescale 1ns/1ns
`default_nettype none
module see_slave_assertions
    import see_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYC
) (
    input wire logic       sys_clk_i,
    input wire logic       srst_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_n_o,
    input wire logic [2:0] chip_select_pins_i,
    input wire logic       busy_o
);
    logic [4:0]  low_ff;
    logic [4:0]  nxt_low;
    int unsigned busy_ff;
    int unsigned nxt_busy;
    always_comb begin
        nxt_low  = scl_i ? 5'h00 : ((low_ff == 5'h1F) ? low_ff : low_ff + 5'h01);
        nxt_busy = busy_o ? busy_ff + 1 : 0;
    end
    always_ff @(posedge sys_clk_i) begin
        low_ff  <= srst_i ? 5'h00 : nxt_low;
        busy_ff <= srst_i ? 0 : nxt_busy;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    a_reset_quiet: assert property ($fell(srst_i) |-> sda_oe_n_o && !busy_o)
        else $error("outputs active after reset");
    a_busy_quiet: assert property (busy_o |-> sda_oe_n_o)
        else $error("data driven while busy");
    a_drive_scl_low: assert property ($fell(sda_oe_n_o) |-> !scl_i)
        else $error("drive started with clock high");
    a_hold_off: assert property ($changed(sda_oe_n_o) && !scl_i |-> low_ff >= 5'd15)
        else $error("data changed too soon after clock fall");
    a_through_high: assert property ($rose(scl_i) && !sda_oe_n_o |=> !sda_oe_n_o [*8])
        else $error("low level not held through clock high");
    a_busy_length: assert property ($fell(busy_o) |-> busy_ff + 1 >= WRITE_CYCLES && busy_ff <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    a_busy_after_stop: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("write cycle began without stop");
    a_drive_level: assert property (!sda_oe_n_o |-> sda_o == 1'b0)
        else $error("driven level not low");
endmodule // see_slave_assertions
bind see_slave see_slave_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) see_slave_assertions_i (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .chip_select_pins_i(chip_select_pins_i), .busy_o(busy_o));
`default_nettype wire

/* File: test/see_master_model.sv */
// Bus master model that clocks the two-wire link and frames transfers.
// Assumes the data wire is resolved outside and fed back on sda_i.
`timescale 1ns/1ns
`default_nettype none
module see_master_model (
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic qtr();
        repeat (25) @(negedge sys_clk_i);
    endtask
    task automatic start_cond();
        sda_o = 1'b1;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_o = 1'b0;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask
    task automatic stop_cond();
        sda_o = 1'b0;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_o = 1'b1;
        qtr();
    endtask
    task automatic xfer_bit(input logic b, output logic r);
        sda_o = b;
        qtr();
        scl_o = 1'b1;
        qtr();
        r = sda_i;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask
    task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], q[i]);
        end
        xfer_bit(ack_in, ack);
    endtask
    task automatic spike_scl();
        scl_o = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        scl_o = 1'b0;
        qtr();
    endtask
endmodule // see_master_model
`default_nettype wire

/* File: test/tb_see_slave.sv */
// Testbench for the serial EEPROM slave with a bus master model.
// Assumes a pull-up on the data wire; the device only pulls it low.
`timescale 1ns/1ns
`default_nettype none
module tb_see_slave;
    import see_pkg::*;
    localparam int unsigned WCYC = 2000;
    localparam logic [2:0]  CS   = 3'b101;
    localparam logic [7:0]  PAT  = 8'hA0;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] cs_pins = CS;
    logic       scl;
    logic       sda_m;
    logic       sda_o;
    logic       sda_oe_n;
    logic       busy;
    logic       ak;
    logic [7:0] q;
    int         failures = 0;
    int         check_count = 0;
    wire logic  sda_w = sda_m & (sda_oe_n | sda_o);
    see_slave #(.WRITE_CYCLES(WCYC)) see_slave_i (.sys_clk_i(sys_clk), .srst_i(srst), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .chip_select_pins_i(cs_pins), .busy_o(busy));
    see_master_model see_master_model_i (.sys_clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tx(input logic [7:0] d, input logic ack_in);
        see_master_model_i.xfer_byte(d, ack_in, q, ak);
    endtask
    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            see_master_model_i.start_cond();
            tx({CTRL_CODE, 3'(s), 1'b0}, 1'b1);
            check("select_ack", 8'(ak), 8'(3'(s) != CS));
            see_master_model_i.stop_cond();
        end
        see_master_model_i.start_cond();
        tx({~CTRL_CODE, CS, 1'b0}, 1'b1);
        check("code_nack", 8'(ak), 8'h01);
        see_master_model_i.stop_cond();
    endtask
    task automatic t_page_write();
        int n;
        see_master_model_i.start_cond();
        see_master_model_i.spike_scl();
        tx({CTRL_CODE, CS, 1'b0}, 1'b1);
        check("ctrl_ack", 8'(ak), 8'h00);
        tx(8'h01, 1'b1);
        tx(8'h1E, 1'b1);
        for (int k = 0; k < 4; k++) begin
            tx(PAT + 8'(k), 1'b1);
            check("data_ack", 8'(ak), 8'h00);
        end
        see_master_model_i.stop_cond();
        repeat (12) @(negedge sys_clk);
        check("busy_on", 8'(busy), 8'h01);
        see_master_model_i.start_cond();
        tx({CTRL_CODE, CS, 1'b0}, 1'b1);
        check("poll_nack", 8'(ak), 8'h01);
        see_master_model_i.stop_cond();
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        check("busy_off", 8'(busy), 8'h00);
    endtask
    task automatic t_read(input logic [11:0] a, input logic [7:0] e0);
        see_master_model_i.start_cond();
        tx({CTRL_CODE, CS, 1'b0}, 1'b1);
        tx({4'h0, a[11:8]}, 1'b1);
        tx(a[7:0], 1'b1);
        see_master_model_i.start_cond();
        tx({CTRL_CODE, CS, 1'b1}, 1'b1);
        check("read_ack", 8'(ak), 8'h00);
        for (int k = 0; k < 2; k++) begin
            tx(8'hFF, 1'(k));
            check("read_data", q, e0 + 8'(k));
        end
        check("nack_release", 8'(sda_oe_n), 8'h01);
        see_master_model_i.stop_cond();
    endtask
    task automatic t_abort();
        logic b;
        see_master_model_i.start_cond();
        tx({CTRL_CODE, CS, 1'b0}, 1'b1);
        tx(8'h01, 1'b1);
        tx(8'h00, 1'b1);
        for (int i = 0; i < 4; i++) begin
            see_master_model_i.xfer_bit(1'b0, b);
        end
        see_master_model_i.stop_cond();
        repeat (12) @(negedge sys_clk);
        check("abort_idle", 8'(busy), 8'h00);
        see_master_model_i.start_cond();
        tx({CTRL_CODE, CS, 1'b0}, 1'b1);
        check("after_abort", 8'(ak), 8'h00);
        see_master_model_i.stop_cond();
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        repeat (10) @(negedge sys_clk);
        check("reset_oe", 8'(sda_oe_n), 8'h01);
        check("reset_busy", 8'(busy), 8'h00);
        t_select();
        t_page_write();
        t_read(12'h11E, PAT);
        t_read(12'h100, PAT + 8'h02);
        t_abort();
        complete_run();
    end
    initial begin
        repeat (80000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
endmodule // tb_see_slave
`default_nettype wire
